/* src/pfe_core.sv */
// Strap capture, control registers and 100 Mbps coding path of the transceiver
`timescale 1ns/1ps
`include "pfe_defines.svh"
module pfe_core
  import pfe_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [6:0] strap_in,
  output logic [6:0] strap_out,
  output logic [6:0] strap_oe,
  output logic [6:0] strap_pull_en,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic [2:0] if_mode,
  output logic [1:0] clk_div_sel,
  input wire logic tx_en,
  input wire logic [3:0] tx_data,
  output logic tx_ready,
  output logic [1:0] mlt3_out,
  input wire logic nrzi_in,
  output logic rx_dv,
  output logic [3:0] rx_data,
  output logic rx_er
);
  typedef struct packed {
    logic strap_done;
    pfe_strap_t strap;
    logic [15:0] ctrl;
    logic [15:0] adv;
    logic [15:0] rdata;
    pfe_tx_st_t tx_st;
    logic [4:0] tx_sh;
    logic [2:0] tx_cnt;
    logic [10:0] tx_scr;
    logic tx_nrzi;
    logic [1:0] mlt_phase;
    logic [1:0] mlt;
    logic [1:0] rx_sync;
    logic rx_prev;
    logic [10:0] rx_scr;
    logic rx_lock;
    logic [9:0] rx_sh;
    pfe_rx_st_t rx_st;
    logic [2:0] rx_cnt;
    logic rx_dv;
    logic [3:0] rx_data;
    logic rx_er;
  } pfe_st_t;
  pfe_st_t st_r, st_nxt;
  logic [4:0] fifo_out;
  logic fifo_valid, fifo_pop, fifo_ready, fifo_push;
  logic [4:0] cg;
  logic [3:0] dec_nib;
  logic dec_ok, tx_bit, scr_bit, nrz_bit, plain_bit, rx_key;
  logic [4:0] rx_cg;
  // MII nibble pushed toward the serialiser, with its fifth bit always zero
  assign fifo_push = tx_en && st_r.strap_done && st_r.ctrl[`PFE_CTRL_SPEED];
  assign tx_ready = fifo_ready;
  pfe_fifo #(.WIDTH(5), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .in_valid(fifo_push),
    .in_ready(fifo_ready),
    .in_data({1'b0, tx_data}),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out)
  );
  function automatic logic [4:0] enc4b5b(input logic [3:0] n);
    logic [4:0] c;
    c = 5'h00;
    case (n)
      4'h0: c = 5'h1E;
      4'h1: c = 5'h09;
      4'h2: c = 5'h14;
      4'h3: c = 5'h15;
      4'h4: c = 5'h0A;
      4'h5: c = 5'h0B;
      4'h6: c = 5'h0E;
      4'h7: c = 5'h0F;
      4'h8: c = 5'h12;
      4'h9: c = 5'h13;
      4'hA: c = 5'h16;
      4'hB: c = 5'h17;
      4'hC: c = 5'h1A;
      4'hD: c = 5'h1B;
      4'hE: c = 5'h1C;
      default: c = 5'h1D;
    endcase
    return c;
  endfunction : enc4b5b
  always_comb begin
    dec_ok = 1'b1;
    dec_nib = 4'h0;
    case (rx_cg)
      5'h1E: dec_nib = 4'h0;
      5'h09: dec_nib = 4'h1;
      5'h14: dec_nib = 4'h2;
      5'h15: dec_nib = 4'h3;
      5'h0A: dec_nib = 4'h4;
      5'h0B: dec_nib = 4'h5;
      5'h0E: dec_nib = 4'h6;
      5'h0F: dec_nib = 4'h7;
      5'h12: dec_nib = 4'h8;
      5'h13: dec_nib = 4'h9;
      5'h16: dec_nib = 4'hA;
      5'h17: dec_nib = 4'hB;
      5'h1A: dec_nib = 4'hC;
      5'h1B: dec_nib = 4'hD;
      5'h1C: dec_nib = 4'hE;
      5'h1D: dec_nib = 4'hF;
      default: dec_ok = 1'b0;
    endcase
  end
  assign rx_cg = st_r.rx_sh[4:0];
  // Serialiser reloads on the last bit of each code group
  assign fifo_pop = (st_r.tx_cnt == 3'h4) && (st_r.tx_st == PFE_TX_DATA);
  assign tx_bit = st_r.tx_sh[4];
  assign scr_bit = tx_bit ^ (st_r.ctrl[`PFE_CTRL_SPEED] & st_r.tx_scr[10]);
  assign nrz_bit = st_r.rx_sync[1] ^ st_r.rx_prev;
  // Register holds past key bits, so the current key is predicted from taps 11 and 9
  assign rx_key = st_r.rx_scr[10] ^ st_r.rx_scr[8];
  assign plain_bit = nrz_bit ^ (st_r.ctrl[`PFE_CTRL_SPEED] & rx_key);
  always_comb begin
    st_nxt = st_r;
    // Straps are caught on the first clock after release, never under async reset
    if (!st_r.strap_done) begin
      st_nxt.strap_done = 1'b1;
      st_nxt.strap.speed_100 = strap_in[0];
      st_nxt.strap.half_duplex = strap_in[1];
      st_nxt.strap.autoneg_en = strap_in[2];
      st_nxt.strap.isolate = strap_in[3];
      st_nxt.strap.if_mode = strap_in[6:4];
      st_nxt.ctrl[`PFE_CTRL_SPEED] = strap_in[0];
      st_nxt.ctrl[`PFE_CTRL_DUPLEX] = strap_in[1];
      st_nxt.ctrl[`PFE_CTRL_ANEN] = strap_in[2];
      st_nxt.ctrl[`PFE_CTRL_ISO] = strap_in[3];
      st_nxt.adv = `PFE_ADV_SEL;
      st_nxt.adv[`PFE_ADV_10HD] = 1'b1;
      st_nxt.adv[`PFE_ADV_10FD] = 1'b1;
      st_nxt.adv[`PFE_ADV_100HD] = strap_in[0];
      st_nxt.adv[`PFE_ADV_100FD] = strap_in[0];
    end else if (reg_wr) begin
      if (reg_addr == `PFE_REG_CTRL) st_nxt.ctrl = reg_wdata;
      if (reg_addr == `PFE_REG_ADV) st_nxt.adv = reg_wdata;
    end
    // Unmapped offsets read zero
    if (reg_rd) begin
      case (reg_addr)
        `PFE_REG_CTRL: st_nxt.rdata = st_r.ctrl;
        `PFE_REG_ADV: st_nxt.rdata = st_r.adv;
        default: st_nxt.rdata = 16'h0000;
      endcase
    end
    // Transmit: 5 bit times per code group
    st_nxt.tx_cnt = (st_r.tx_cnt == 3'h4) ? 3'h0 : st_r.tx_cnt + 3'h1;
    if (st_r.tx_cnt == 3'h4) begin
      case (st_r.tx_st)
        PFE_TX_IDLE: begin
          if (fifo_valid) begin
            st_nxt.tx_sh = `PFE_CG_J;
            st_nxt.tx_st = PFE_TX_DATA;
          end else begin
            st_nxt.tx_sh = `PFE_CG_IDLE;
          end
        end
        PFE_TX_DATA: begin
          if (fifo_valid) begin
            st_nxt.tx_sh = enc4b5b(fifo_out[3:0]);
          end else begin
            st_nxt.tx_sh = `PFE_CG_T;
            st_nxt.tx_st = PFE_TX_END;
          end
        end
        PFE_TX_END: begin
          st_nxt.tx_sh = `PFE_CG_R;
          st_nxt.tx_st = PFE_TX_IDLE;
        end
        default: st_nxt.tx_st = PFE_TX_IDLE;
      endcase
    end else begin
      st_nxt.tx_sh = {st_r.tx_sh[3:0], 1'b0};
    end
    // Known simplification: K of the start delimiter is folded into J
    st_nxt.tx_scr = {st_r.tx_scr[9:0], st_r.tx_scr[10] ^ st_r.tx_scr[8]};
    st_nxt.tx_nrzi = st_r.tx_nrzi ^ scr_bit;
    if (st_nxt.tx_nrzi != st_r.tx_nrzi) begin
      st_nxt.mlt_phase = st_r.mlt_phase + 2'h1;
      case (st_r.mlt_phase)
        2'h0: st_nxt.mlt = 2'b01;
        2'h1: st_nxt.mlt = 2'b00;
        2'h2: st_nxt.mlt = 2'b11;
        default: st_nxt.mlt = 2'b00;
      endcase
    end
    // Receive: line sampled through two flops, an edge between samples is a one
    st_nxt.rx_sync = {st_r.rx_sync[0], nrzi_in};
    st_nxt.rx_prev = st_r.rx_sync[1];
    st_nxt.rx_scr = {st_r.rx_scr[9:0], rx_key};
    // Self-synchronise: idle is all ones, so ciphertext reveals the key stream
    if (!st_r.rx_lock) begin
      st_nxt.rx_scr = {st_r.rx_scr[9:0], ~nrz_bit};
    end
    // Ten decoded ones prove the key; it then runs free so delimiters cannot spoil it
    if (st_r.rx_sh == 10'h3FF) st_nxt.rx_lock = 1'b1;
    st_nxt.rx_sh = {st_r.rx_sh[8:0], plain_bit};
    st_nxt.rx_cnt = (st_r.rx_cnt == 3'h4) ? 3'h0 : st_r.rx_cnt + 3'h1;
    case (st_r.rx_st)
      PFE_RX_HUNT: begin
        if (st_r.rx_lock && st_r.rx_sh[4:0] == `PFE_CG_J) begin
          st_nxt.rx_st = PFE_RX_DATA;
          st_nxt.rx_cnt = 3'h1;
        end
        st_nxt.rx_dv = 1'b0;
      end
      PFE_RX_SSD: st_nxt.rx_st = PFE_RX_DATA;
      PFE_RX_DATA: begin
        if (st_r.rx_cnt == 3'h0) begin
          if (rx_cg == `PFE_CG_T || rx_cg == `PFE_CG_IDLE) begin
            st_nxt.rx_st = PFE_RX_HUNT;
            st_nxt.rx_dv = 1'b0;
            st_nxt.rx_er = 1'b0;
          end else begin
            st_nxt.rx_dv = 1'b1;
            st_nxt.rx_data = dec_nib;
            st_nxt.rx_er = !dec_ok;
          end
        end
      end
      default: st_nxt.rx_st = PFE_RX_HUNT;
    endcase
    if (!st_r.ctrl[`PFE_CTRL_SPEED]) st_nxt.rx_dv = 1'b0;
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
      st_r.tx_st <= PFE_TX_IDLE;
      st_r.rx_st <= PFE_RX_HUNT;
      st_r.tx_sh <= `PFE_CG_IDLE;
      st_r.tx_scr <= `PFE_SCR_SEED;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign reg_rdata = st_r.rdata;
  assign if_mode = st_r.strap.if_mode;
  // 00: 25 MHz ref, 01: 50 MHz ref, 10: loopback on 25 MHz, 11: reserved
  assign clk_div_sel = (st_r.strap.if_mode == `PFE_MODE_RMII) ? 2'h1 :
    (st_r.strap.if_mode == `PFE_MODE_PCSLB) ? 2'h2 :
    (st_r.strap.if_mode == `PFE_MODE_MII) ? 2'h0 : 2'h3;
  assign strap_oe = {7{st_r.strap_done}};
  assign strap_pull_en = {7{~st_r.strap_done}};
  assign strap_out = 7'h00;
  assign mlt3_out = st_r.mlt;
  assign rx_dv = st_r.rx_dv;
  assign rx_data = st_r.rx_data;
  assign rx_er = st_r.rx_er;
  strap_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $past(st_r.strap_done) |-> $stable(st_r.strap)) else $error("Strap changed");
  speed_cap_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(st_r.strap_done) |-> st_r.adv[`PFE_ADV_100HD] == st_r.strap.speed_100)
    else $error("Advertised speed mismatch");
  ctrl_strap_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(st_r.strap_done) |-> st_r.ctrl[`PFE_CTRL_SPEED] == $past(strap_in[0])
    && st_r.ctrl[`PFE_CTRL_DUPLEX] == $past(strap_in[1])) else $error("Strap capture");
  anen_iso_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(st_r.strap_done) |-> st_r.ctrl[`PFE_CTRL_ANEN] == $past(strap_in[2])
    && st_r.ctrl[`PFE_CTRL_ISO] == $past(strap_in[3])) else $error("Strap capture");
  pin_dir_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    strap_oe == ~strap_pull_en) else $error("Strap pin direction");
  group_len_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    st_r.tx_cnt == 3'h4 |=> st_r.tx_cnt == 3'h0 ##4 st_r.tx_cnt == 3'h4)
    else $error("Code group length");
  mlt_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $stable(st_r.tx_nrzi) |-> $stable(st_r.mlt)) else $error("MLT3 moved on zero");
  mlt_zero_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    st_r.mlt_phase[0] == 1'b0 |-> st_r.mlt == 2'b00) else $error("MLT3 phase");
  mode_sel_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    st_r.strap.if_mode == `PFE_MODE_RMII |-> clk_div_sel == 2'h1)
    else $error("RMII reference");
  no_scr10_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !st_r.ctrl[`PFE_CTRL_SPEED] |-> scr_bit == tx_bit) else $error("Scrambled at 10M");
  hunt_lock_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !st_r.rx_lock |-> st_r.rx_st == PFE_RX_HUNT && !st_r.rx_dv) else $error("Frame before lock");
endmodule : pfe_core

/* src/pfe_defines.svh */
// Register offsets, field positions, strap codes, code groups and clock rates for the strap and coding block
`ifndef PFE_DEFINES_SVH
`define PFE_DEFINES_SVH
`define PFE_REG_CTRL 5'h00
`define PFE_REG_ADV 5'h04
`define PFE_CTRL_SPEED 13
`define PFE_CTRL_ANEN 12
`define PFE_CTRL_ISO 10
`define PFE_CTRL_DUPLEX 8
`define PFE_ADV_100FD 8
`define PFE_ADV_100HD 7
`define PFE_ADV_10FD 6
`define PFE_ADV_10HD 5
`define PFE_ADV_SEL 16'h0001
`define PFE_MODE_MII 3'h0
`define PFE_MODE_RMII 3'h1
`define PFE_MODE_PCSLB 3'h4
`define PFE_CG_IDLE 5'h1F
`define PFE_CG_J 5'h18
`define PFE_CG_K 5'h11
`define PFE_CG_T 5'h0D
`define PFE_CG_R 5'h07
`define PFE_SCR_SEED 11'h7FF
`define PFE_BIT_HZ 125000000
`define PFE_SYS_HZ 100000000
`endif

/* src/pfe_pkg.sv */
// Types shared by the strap and coding block
package pfe_pkg;
  typedef enum logic [2:0] {
    PFE_TX_IDLE = 3'b001,
    PFE_TX_DATA = 3'b010,
    PFE_TX_END = 3'b100
  } pfe_tx_st_t;
  typedef enum logic [2:0] {
    PFE_RX_HUNT = 3'b001,
    PFE_RX_SSD = 3'b010,
    PFE_RX_DATA = 3'b100
  } pfe_rx_st_t;
  typedef struct packed {
    logic speed_100;
    logic autoneg_en;
    logic isolate;
    logic half_duplex;
    logic [2:0] if_mode;
  } pfe_strap_t;
  typedef struct packed {
    logic [4:0] data;
    logic valid;
  } pfe_mii_t;
endpackage : pfe_pkg

/* src/pfe_fifo.sv */
// Parameterised FIFO between the MII transmit nibbles and the code-group serialiser
`timescale 1ns/1ps
module pfe_fifo
  import pfe_pkg::*;
#(
  parameter int WIDTH = 5,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
    logic [WIDTH-1:0] q;
    logic qv;
  } pfe_fifo_st_t;
  pfe_fifo_st_t st_r, st_nxt;
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic full, empty, push, pop;
  assign full = (st_r.wp[AW] != st_r.rp[AW]) && (st_r.wp[AW-1:0] == st_r.rp[AW-1:0]);
  assign empty = st_r.wp == st_r.rp;
  assign in_ready = !full;
  assign push = in_valid && !full;
  // Registered read stage so read data leave a flip-flop
  assign pop = !empty && (!st_r.qv || out_ready);
  assign out_valid = st_r.qv;
  assign out_data = st_r.q;
  always_comb begin
    st_nxt = st_r;
    if (push) st_nxt.wp = st_r.wp + 1'b1;
    if (out_ready && st_r.qv) st_nxt.qv = 1'b0;
    if (pop) begin
      st_nxt.rp = st_r.rp + 1'b1;
      st_nxt.q = mem_r[st_r.rp[AW-1:0]];
      st_nxt.qv = 1'b1;
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) st_r <= '0;
    else st_r <= st_nxt;
  end
  always_ff @(posedge clk_sys) begin
    if (push) mem_r[st_r.wp[AW-1:0]] <= in_data;
  end
  fifo_level_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (st_r.wp - st_r.rp) <= (AW+1)'(DEPTH)) else $error("FIFO level beyond depth");
endmodule : pfe_fifo

/* testbench/pfe_mac_model.sv */
// Behavioural MAC on the MII side: sends nibble frames and collects received nibbles
`timescale 1ns/1ps
module pfe_mac_model
  import pfe_pkg::*;
(
  input wire logic clk_sys,
  output logic tx_en,
  output logic [3:0] tx_data,
  input wire logic tx_ready,
  input wire logic rx_dv,
  input wire logic [3:0] rx_data,
  input wire logic rx_er
);
  logic [3:0] rx_q[$];
  int stall_cnt = 0;
  int er_cnt = 0;
  int ph = 0;
  logic dv_q = 1'b0;
  initial begin
    tx_en = 1'b0;
    tx_data = 4'h0;
  end
  // Nibbles go back to back; each is held until ready is seen high before an edge
  task automatic send_frame(input int n);
    logic ok;
    @(posedge clk_sys);
    for (int i = 0; i < n; i++) begin
      tx_en <= 1'b1;
      tx_data <= 4'(i * 7 + 3);
      do begin
        @(negedge clk_sys);
        ok = tx_ready;
        if (ok !== 1'b1) stall_cnt++;
        @(posedge clk_sys);
      end while (ok !== 1'b1);
    end
    tx_en <= 1'b0;
    // Released data lines must not look like the last nibble
    tx_data <= ~tx_data;
  endtask : send_frame
  // Valid stands for the whole frame; a new nibble stands every five clocks
  always @(posedge clk_sys) begin
    if (rx_dv === 1'b1 && (dv_q !== 1'b1 || ph == 4)) begin
      rx_q.push_back(rx_data);
      ph = 0;
    end else begin
      ph = ph + 1;
    end
    dv_q = rx_dv;
    if (rx_er === 1'b1) er_cnt++;
  end
endmodule : pfe_mac_model

/* testbench/tb_pfe_core.sv */
// Self-checking bench for strap capture, registers and the 100 Mbps coding path
`timescale 1ns/1ps
`include "pfe_defines.svh"
module tb_pfe_core
  import pfe_pkg::*;
;
  typedef struct packed {logic [6:0] strap; logic [15:0] ctrl; logic [1:0] div;} pfe_tb_row_t;
  localparam int NNIB = 24;
  localparam pfe_tb_row_t ROWS [4] = '{
    '{7'h07, 16'h3100, 2'h0}, '{7'h1A, 16'h0500, 2'h1},
    '{7'h45, 16'h3000, 2'h2}, '{7'h30, 16'h0000, 2'h3}};
  logic clk_sys = 1'b0;
  logic reset_n, reg_wr, reg_rd, nrzi_in, tx_en, tx_ready, rx_dv, rx_er;
  logic [6:0] strap_in, strap_out, strap_oe, strap_pull_en;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rd_v;
  logic [2:0] if_mode;
  logic [1:0] clk_div_sel, mlt3_out, mlt3_prev, last_nz, exp_lvl;
  logic [3:0] tx_data, rx_data;
  logic nrzi_line = 1'b0;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int tr_cnt = 0;
  int tr_mark;
  always #5 clk_sys = ~clk_sys;
  assign nrzi_in = nrzi_line;
  pfe_core #(.FIFO_DEPTH(16)) pfe_core_inst (.clk_sys(clk_sys), .reset_n(reset_n),
    .strap_in(strap_in), .strap_out(strap_out), .strap_oe(strap_oe),
    .strap_pull_en(strap_pull_en), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .if_mode(if_mode),
    .clk_div_sel(clk_div_sel), .tx_en(tx_en), .tx_data(tx_data), .tx_ready(tx_ready),
    .mlt3_out(mlt3_out), .nrzi_in(nrzi_in), .rx_dv(rx_dv), .rx_data(rx_data), .rx_er(rx_er));
  pfe_mac_model pfe_mac_model_inst (.clk_sys(clk_sys), .tx_en(tx_en), .tx_data(tx_data),
    .tx_ready(tx_ready), .rx_dv(rx_dv), .rx_data(rx_data), .rx_er(rx_er));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test
  task automatic do_reset(input logic [6:0] s);
    @(posedge clk_sys);
    reset_n <= 1'b0;
    strap_in <= s;
    repeat (3) @(posedge clk_sys);
    chk({2'h0, strap_oe, strap_pull_en}, {2'h0, 7'h00, 7'h7F});
    reset_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
  endtask : do_reset
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    d = reg_rdata;
  endtask : rd
  // Line loopback: every MLT3 level change is one NRZI transition back into the receiver
  always @(posedge clk_sys) begin
    if (reset_n !== 1'b1) begin
      mlt3_prev <= 2'b00;
      last_nz <= 2'b11;
    end else begin
      if (mlt3_out !== mlt3_prev) begin
        tr_cnt++;
        exp_lvl = (mlt3_prev == 2'b00) ? ((last_nz == 2'b01) ? 2'b11 : 2'b01) : 2'b00;
        chk({14'h0, mlt3_out}, {14'h0, exp_lvl});
        nrzi_line <= ~nrzi_line;
      end
      if (mlt3_out != 2'b00) last_nz <= mlt3_out;
      mlt3_prev <= mlt3_out;
    end
  end
  // Whole run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, cyc, 0);
      end_of_test;
    end
  end
  initial begin
    reset_n = 1'b0;
    strap_in = 7'h07;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    foreach (ROWS[i]) begin
      do_reset(ROWS[i].strap);
      rd(`PFE_REG_CTRL, rd_v);
      chk(rd_v & 16'h3500, ROWS[i].ctrl);
      rd(`PFE_REG_ADV, rd_v);
      chk(rd_v, {7'h00, ROWS[i].strap[0], ROWS[i].strap[0], 2'b11, 5'h01});
      chk({13'h0, if_mode}, {13'h0, ROWS[i].strap[6:4]});
      chk({14'h0, clk_div_sel}, {14'h0, ROWS[i].div});
      chk({2'h0, strap_oe, strap_pull_en}, {2'h0, 7'h7F, 7'h00});
      @(posedge clk_sys);
      strap_in <= ~ROWS[i].strap;
      rd(`PFE_REG_CTRL, rd_v);
      chk(rd_v & 16'h3500, ROWS[i].ctrl);
    end
    do_reset(ROWS[0].strap);
    wr(`PFE_REG_CTRL, 16'h1100);
    rd(`PFE_REG_CTRL, rd_v);
    chk(rd_v & 16'h3500, 16'h1100);
    wr(`PFE_REG_ADV, 16'h01E1);
    rd(`PFE_REG_ADV, rd_v);
    chk(rd_v, 16'h01E1);
    rd(5'h1F, rd_v);
    chk(rd_v, 16'h0000);
    // Idle first so the descrambler can lock before the frame
    do_reset(ROWS[0].strap);
    repeat (60) @(posedge clk_sys);
    pfe_mac_model_inst.send_frame(NNIB);
    chk({15'h0, pfe_mac_model_inst.stall_cnt != 0}, 16'h0001);
    for (int w = 0; w < 800 && pfe_mac_model_inst.rx_q.size() < NNIB; w++) @(posedge clk_sys);
    repeat (20) @(posedge clk_sys);
    chk(16'(pfe_mac_model_inst.rx_q.size()), 16'(NNIB));
    for (int i = 0; i < NNIB && i < pfe_mac_model_inst.rx_q.size(); i++) begin
      chk({12'h0, pfe_mac_model_inst.rx_q[i]}, {12'h0, 4'(i * 7 + 3)});
    end
    chk(16'(pfe_mac_model_inst.er_cnt), 16'h0000);
    chk({15'h0, tx_ready}, 16'h0001);
    // At 10 Mbps idle goes out unscrambled, so the line steps on every bit
    do_reset(7'h06);
    @(negedge clk_sys);
    tr_mark = tr_cnt;
    repeat (50) @(negedge clk_sys);
    chk(16'(tr_cnt - tr_mark), 16'h0032);
    end_of_test;
  end
endmodule : tb_pfe_core
